// ==== hdl/dual_channel_torque_shutoff.sv ====
/*
  Safe torque shutoff supervisor: two redundant shutoff channels, skew check,
  power stage enable, recoverable and power-cycle-only faults.
  Assumes shutoff inputs are asynchronous pins, high when energized, and that
  enable_cmd, fault_reset and restart_on_power_up come from core_clk logic.
*/
// Summary of operation
// - two independent shutoff channels are accepted and either can start torque removal.
// - both channels off within the skew limit disables the power stage and raises a fault.
// - after a two-channel shutoff, running resumes only after a fault-reset clears the fault.
// - a single channel or late switch disables the power stage and latches a fault until a power cycle.
// - standstill is not supervised; torque removal is the only action taken.
// - on shutoff torque is removed at once; the holding-brake delay is bypassed once a fault is raised.
// - with restart_on_power_up off the stage is not re-enabled after power-up by itself.
`timescale 1ns/1ps
`include "torque_shutoff_regs.svh"

module dual_channel_torque_shutoff
  import torque_shutoff_pkg::*;
#(
  parameter int unsigned SKEW_LIMIT_CYCLES = `SKEW_LIMIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic shutoff_input_a,
  input wire logic shutoff_input_b,
  input wire logic enable_cmd,
  input wire logic fault_reset,
  input wire logic restart_on_power_up,
  output logic power_stage_enable,
  output logic brake_delay_bypass,
  output logic shutoff_fault,
  output logic locked_fault
);

  localparam logic [`SKEW_CNT_W-1:0] SKEW_LAST = `SKEW_CNT_W'(SKEW_LIMIT_CYCLES - 1);
  localparam logic [`SKEW_CNT_W-1:0] SETTLE_LAST = `SKEW_CNT_W'(`SETTLE_CYCLES - 1);

  shutoff_regs_type st_reg;
  shutoff_regs_type st_next;
  logic a_on;
  logic b_on;
  logic mismatch;

  ////////////////////////////////////////////////////////////////////////////
  // channel levels

  assign a_on = st_reg.a_sync;
  assign b_on = st_reg.b_sync;
  assign mismatch = a_on ^ b_on;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers, reset low so a lost signal reads as shutoff
    st_next.a_meta = shutoff_input_a;
    st_next.a_sync = st_reg.a_meta;
    st_next.b_meta = shutoff_input_b;
    st_next.b_sync = st_reg.b_meta;
    // an enable must be seen low before it may start the stage again
    st_next.armed = st_reg.armed | ~enable_cmd;
    case (st_reg.fsm)
      ST_INIT: begin
        st_next.skew_cnt = st_reg.skew_cnt + `SKEW_CNT_W'(1);
        if (st_reg.skew_cnt == SETTLE_LAST) begin
          st_next.skew_cnt = '0;
          // automatic enable only when configured on
          st_next.armed = restart_on_power_up;
          if (!a_on && !b_on) begin
            st_next.fsm = ST_SHUTOFF_FAULT;
          end else if (mismatch) begin
            st_next.fsm = ST_IDLE;
          end else begin
            st_next.fsm = ST_IDLE;
          end
        end
      end
      ST_IDLE, ST_RUN: begin
        if (!a_on && !b_on && st_reg.skew_cnt != SKEW_LAST) begin
          st_next.fsm = ST_SHUTOFF_FAULT;
          st_next.skew_cnt = '0;
        end else if (mismatch) begin
          // skew counted from the first channel to drop
          st_next.fsm = ST_IDLE;
          if (st_reg.skew_cnt == SKEW_LAST) begin
            st_next.fsm = ST_LOCKED;
          end else begin
            st_next.skew_cnt = st_reg.skew_cnt + `SKEW_CNT_W'(1);
          end
        end else if (st_reg.skew_cnt != '0) begin
          // lone channel came back before its partner dropped
          st_next.fsm = ST_LOCKED;
        end else if (st_reg.fsm == ST_RUN) begin
          if (!enable_cmd) begin
            st_next.fsm = ST_IDLE;
          end
        end else if (enable_cmd && st_reg.armed) begin
          st_next.fsm = ST_RUN;
          st_next.armed = 1'b0;
        end
      end
      ST_SHUTOFF_FAULT: begin
        if (mismatch) begin
          if (st_reg.skew_cnt == SKEW_LAST) begin
            st_next.fsm = ST_LOCKED;
          end else begin
            st_next.skew_cnt = st_reg.skew_cnt + `SKEW_CNT_W'(1);
          end
        end else begin
          st_next.skew_cnt = '0;
          // reset accepted only with both channels energized again
          if (fault_reset && a_on && b_on) begin
            st_next.fsm = ST_IDLE;
            st_next.armed = 1'b0;
          end
        end
      end
      ST_LOCKED: begin
        // only a power cycle (arst_n) leaves this state
        st_next.fsm = ST_LOCKED;
      end
      default: begin
        st_next.fsm = ST_LOCKED;
      end
    endcase
    // outputs registered from the next state; no standstill check exists
    st_next.power_enable = (st_next.fsm == ST_RUN);
    // stage drops at or before the edge the fault appears, with no brake bridging
    st_next.brake_bypass = (st_next.fsm == ST_SHUTOFF_FAULT) ||
      (st_next.fsm == ST_LOCKED);
    st_next.shutoff_fault = (st_next.fsm == ST_SHUTOFF_FAULT);
    st_next.locked_fault = (st_next.fsm == ST_LOCKED);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{fsm: ST_INIT, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign power_stage_enable = st_reg.power_enable;
  assign brake_delay_bypass = st_reg.brake_bypass;
  assign shutoff_fault = st_reg.shutoff_fault;
  assign locked_fault = st_reg.locked_fault;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_both_off_removes_torque;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.fsm == ST_RUN && !a_on && !b_on)
      |=> (!power_stage_enable && shutoff_fault && brake_delay_bypass);
  endproperty
  a_both_off_removes_torque: assert property (p_both_off_removes_torque)
    else $error("both channels off but torque not removed");

  property p_fault_holds_until_reset;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.fsm == ST_SHUTOFF_FAULT && !fault_reset && !mismatch) |=> shutoff_fault;
  endproperty
  a_fault_holds_until_reset: assert property (p_fault_holds_until_reset)
    else $error("shutoff fault left without fault reset");

  property p_reset_then_idle;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.fsm == ST_SHUTOFF_FAULT && fault_reset && a_on && b_on)
      |=> (!shutoff_fault && !power_stage_enable) ##1 !power_stage_enable;
  endproperty
  a_reset_then_idle: assert property (p_reset_then_idle)
    else $error("fault reset restarted the stage without fresh enable");

  property p_locked_sticks;
    @(posedge core_clk) disable iff (!arst_n)
      locked_fault |=> (locked_fault && !power_stage_enable);
  endproperty
  a_locked_sticks: assert property (p_locked_sticks)
    else $error("latched fault cleared without power cycle");

  property p_lone_channel_locks;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.fsm == ST_IDLE && st_reg.skew_cnt != '0 && a_on && b_on) |=> locked_fault;
  endproperty
  a_lone_channel_locks: assert property (p_lone_channel_locks)
    else $error("single channel shutoff did not latch");

  property p_skew_limit;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.skew_cnt == SKEW_LAST && mismatch && st_reg.fsm != ST_INIT) |=> locked_fault;
  endproperty
  a_skew_limit: assert property (p_skew_limit)
    else $error("skew limit passed without latched fault");

  property p_brake_bypass_on_drop;
    @(posedge core_clk) disable iff (!arst_n)
      ($fell(power_stage_enable) && (shutoff_fault || locked_fault)) |-> brake_delay_bypass;
  endproperty
  a_brake_bypass_on_drop: assert property (p_brake_bypass_on_drop)
    else $error("brake delay not bypassed on shutoff");

  // no bridging time: the stage is off the edge after any channel is seen low
  property p_drop_at_once;
    @(posedge core_clk) disable iff (!arst_n)
      (st_reg.fsm == ST_RUN && !(a_on && b_on)) |=> !power_stage_enable;
  endproperty
  a_drop_at_once: assert property (p_drop_at_once)
    else $error("power stage held after a channel dropped");

  property p_fresh_enable;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(power_stage_enable) |-> $past(st_reg.armed, 1);
  endproperty
  a_fresh_enable: assert property (p_fresh_enable)
    else $error("power stage enabled without a fresh enable");

  property p_lost_signal;
    @(posedge core_clk) disable iff (!arst_n)
      (!shutoff_input_a && !shutoff_input_b)[*3] |=> ##1 !power_stage_enable;
  endproperty
  a_lost_signal: assert property (p_lost_signal)
    else $error("de-energized channels left the stage enabled");

endmodule

// ==== hdl/torque_shutoff_pkg.sv ====
/*
  Types for the dual channel torque shutoff block.
  Assumes torque_shutoff_regs.svh is on the include path.
*/
`include "torque_shutoff_regs.svh"

package torque_shutoff_pkg;

  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_IDLE = 5'h02,
    ST_RUN = 5'h04,
    ST_SHUTOFF_FAULT = 5'h08,
    ST_LOCKED = 5'h10
  } shutoff_state_type;

  typedef struct packed {
    shutoff_state_type fsm;
    logic a_meta;
    logic a_sync;
    logic b_meta;
    logic b_sync;
    logic [`SKEW_CNT_W-1:0] skew_cnt;
    logic armed;
    logic power_enable;
    logic brake_bypass;
    logic shutoff_fault;
    logic locked_fault;
  } shutoff_regs_type;

endpackage

// ==== hdl/torque_shutoff_regs.svh ====
/*
  Timing counts and widths for the dual channel torque shutoff block.
  Assumes a single 250 MHz core clock.
*/
`ifndef TORQUE_SHUTOFF_REGS_SVH
`define TORQUE_SHUTOFF_REGS_SVH

`define CORE_CLK_HZ 250000000
// largest allowed skew between the two channels, in seconds
`define SKEW_LIMIT_S 1
`define SKEW_LIMIT_CYCLES (`SKEW_LIMIT_S * `CORE_CLK_HZ)
`define SKEW_CNT_W 28
// cycles after reset before the synchronised channels are trusted
`define SETTLE_CYCLES 3

`endif

// ==== tb/dual_channel_torque_shutoff_test.sv ====
/*
  Self-checking bench for the dual channel torque shutoff block.
  Assumes a shortened skew limit of 20 cycles and the shutoff_source model.
*/
`timescale 1ns/1ps

module dual_channel_torque_shutoff_test;
  import torque_shutoff_pkg::*;
  localparam int unsigned LIMIT = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic enable_cmd = 1'b0;
  logic fault_reset = 1'b0;
  logic restart_on_power_up = 1'b0;
  logic stop_req = 1'b0;
  logic lone_drop = 1'b0;
  logic [7:0] b_lag = 8'h00;
  logic shutoff_input_a, shutoff_input_b;
  logic power_stage_enable, brake_delay_bypass, shutoff_fault, locked_fault;
  int errors = 0;
  int checks = 0;

  initial forever #2 core_clk = ~core_clk;

  shutoff_source u_shutoff_source (.core_clk(core_clk), .stop_req(stop_req),
    .lone_drop(lone_drop), .b_lag(b_lag), .shutoff_input_a(shutoff_input_a),
    .shutoff_input_b(shutoff_input_b));

  dual_channel_torque_shutoff #(.SKEW_LIMIT_CYCLES(LIMIT)) u_dual_channel_torque_shutoff (
    .core_clk(core_clk), .arst_n(arst_n), .shutoff_input_a(shutoff_input_a),
    .shutoff_input_b(shutoff_input_b), .enable_cmd(enable_cmd), .fault_reset(fault_reset),
    .restart_on_power_up(restart_on_power_up), .power_stage_enable(power_stage_enable),
    .brake_delay_bypass(brake_delay_bypass), .shutoff_fault(shutoff_fault),
    .locked_fault(locked_fault));

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // outputs as {power, bypass, fault, locked}, waited for within lim cycles
  task automatic expect_out(input logic [3:0] exp, input int lim);
    logic [3:0] got;
    got = {power_stage_enable, brake_delay_bypass, shutoff_fault, locked_fault};
    for (int i = 0; i < lim && got !== exp; i++) begin
      @(negedge core_clk);
      got = {power_stage_enable, brake_delay_bypass, shutoff_fault, locked_fault};
    end
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic power_up(input logic cfg);
    arst_n = 1'b0;
    restart_on_power_up = cfg;
    cycles(6);
    arst_n = 1'b1;
  endtask

  task automatic enable_edge();
    enable_cmd = 1'b0;
    cycles(1);
    enable_cmd = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_no_auto_start();
    enable_cmd = 1'b1;
    power_up(1'b0);
    cycles(12);
    expect_out(4'h0, 0);
    enable_edge();
    expect_out(4'h8, 3);
    enable_cmd = 1'b0;
    expect_out(4'h0, 3);
    enable_cmd = 1'b1;
    expect_out(4'h8, 3);
    $display("test no_auto_start done");
  endtask

  task automatic test_two_channel(input logic [7:0] lag);
    b_lag = lag;
    stop_req = 1'b1;
    expect_out(4'h6, 8 + lag);
    fault_reset = 1'b1;
    cycles(1);
    fault_reset = 1'b0;
    cycles(3);
    expect_out(4'h6, 0);
    stop_req = 1'b0;
    cycles(4);
    fault_reset = 1'b1;
    cycles(1);
    fault_reset = 1'b0;
    expect_out(4'h0, 3);
    enable_edge();
    expect_out(4'h8, 3);
    $display("test two_channel lag %0d done", lag);
  endtask

  task automatic test_single_channel();
    lone_drop = 1'b1;
    stop_req = 1'b1;
    expect_out(4'h5, LIMIT + 12);
    stop_req = 1'b0;
    lone_drop = 1'b0;
    cycles(4);
    fault_reset = 1'b1;
    cycles(1);
    fault_reset = 1'b0;
    cycles(4);
    expect_out(4'h5, 0);
    power_up(1'b1);
    expect_out(4'h8, 12);
    $display("test single_channel done");
  endtask

  task automatic test_lone_return();
    lone_drop = 1'b1;
    stop_req = 1'b1;
    cycles(8);
    expect_out(4'h0, 0);
    stop_req = 1'b0;
    expect_out(4'h5, 8);
    lone_drop = 1'b0;
    power_up(1'b1);
    expect_out(4'h8, 12);
    $display("test lone_return done");
  endtask

  initial begin
    #(4 * 3000);
    errors++;
    results();
  end

  initial begin
    test_no_auto_start();
    test_two_channel(8'h00);
    test_two_channel(8'h0a);
    test_single_channel();
    test_lone_return();
    results();
  end
endmodule

// ==== tb/shutoff_source.sv ====
/*
  Model of the emergency-stop module driving both shutoff channels.
  Assumes core_clk from the bench; channels change at the falling edge.
*/
`timescale 1ns/1ps

module shutoff_source #(
  parameter int unsigned STOP_DELAY = 4
) (
  input wire logic core_clk,
  input wire logic stop_req,
  input wire logic lone_drop,
  input wire logic [7:0] b_lag,
  output logic shutoff_input_a,
  output logic shutoff_input_b
);
  int unsigned cnt = 0;
  logic drop_a = 1'b0;
  logic drop_b = 1'b0;
  initial shutoff_input_a = 1'b1;
  initial shutoff_input_b = 1'b1;
  // requests are counted on the rising edge, where the bench holds them still
  always @(posedge core_clk) begin
    cnt <= stop_req ? cnt + 1 : 0;
    drop_a <= stop_req && cnt >= STOP_DELAY;
    drop_b <= stop_req && !lone_drop && cnt >= STOP_DELAY + b_lag;
  end
  // channels drop only after the safe delay, b lagging by b_lag; with lone_drop set only a drops
  always @(negedge core_clk) begin
    shutoff_input_a <= !drop_a;
    shutoff_input_b <= !drop_b;
  end
endmodule
